// *** pkg/aqs_map.svh ***
`ifndef AQS_MAP_SVH
`define AQS_MAP_SVH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define AQS_ADDR_W        24
`define AQS_TABLE_BASE    24'h004a00
`define AQS_TABLE_SHIFT   7
`define AQS_STATUS_ADDR   24'h304812
`define AQS_STATUS_RESET  16'h3f3f
`define AQS_Q1PTR_LSB     8
`define AQS_Q2PTR_LSB     0

// ----------------------------------------------------------------
// Queue layout and timing
// ----------------------------------------------------------------
`define AQS_PTR_RESET     6'h3f
`define AQS_END_CHAN      6'h3f
`define AQS_LAST_ENTRY    6'h3f
`define AQS_Q1_START      7'h00
`define AQS_TABLE_DEPTH   64
`define AQS_SAMPLE_MIN    5'h02

`endif

// *** pkg/aqs_pkg.sv ***
package aqs_pkg;

    // Low ten bits of a table word, upper six are not stored
    typedef struct packed {
        logic       pause;
        logic       amp_skip;
        logic [1:0] sample_window_code;
        logic [5:0] channel;
    } aqs_cmd_t;

    typedef struct packed {
        logic [5:0] channel;
        logic       amp_skip;
        logic [1:0] sample_window_code;
        logic [5:0] index;
    } aqs_conv_t;

    typedef enum logic [2:0] {
        MODE_OFF        = 3'h0,
        MODE_SW_SINGLE  = 3'h1,
        MODE_EXT_SINGLE = 3'h2,
        MODE_TMR_SINGLE = 3'h3,
        MODE_SW_CONT    = 3'h4,
        MODE_EXT_CONT   = 3'h5,
        MODE_TMR_CONT   = 3'h6,
        MODE_GATE_CONT  = 3'h7
    } aqs_mode_t;

    typedef enum logic [3:0] {
        ST_IDLE    = 4'h1,
        ST_FETCH   = 4'h2,
        ST_SAMPLE  = 4'h4,
        ST_RESOLVE = 4'h8
    } aqs_state_t;

endpackage : aqs_pkg

// *** rtl/aqs_cmd_table.sv ***
`timescale 1ns/1ps

module aqs_cmd_table #(
    parameter int DEPTH = 64
) (
    input  wire logic             clock,
    input  wire logic             wr_en,
    input  wire logic [5:0]       wr_index,
    input  wire aqs_pkg::aqs_cmd_t wr_data,
    input  wire logic [5:0]       bus_index,
    output aqs_pkg::aqs_cmd_t     bus_data,
    input  wire logic [5:0]       seq_index,
    output aqs_pkg::aqs_cmd_t     seq_data
);
    import aqs_pkg::*;

    // Only software writes; the sequencer has a read port only
    aqs_cmd_t words [DEPTH];

    always_ff @(posedge clock) begin
        if (wr_en) begin
            words[wr_index] <= wr_data;
        end
    end

    assign bus_data = words[bus_index];
    assign seq_data = words[seq_index];

endmodule : aqs_cmd_table

// *** rtl/aqs_sample_timer.sv ***
`timescale 1ns/1ps
`include "aqs_map.svh"

module aqs_sample_timer #(
    parameter int CNT_W = 5
) (
    input  wire logic       clock,
    input  wire logic       reset,
    input  wire logic       start,
    input  wire logic       abort,
    input  wire logic [1:0] code,
    input  wire logic       conv_tick,
    output logic            done
);
    import aqs_pkg::*;

    logic             running;
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] target;
    logic [CNT_W-1:0] next_count;

    assign next_count = count + 1'b1;

    // Counts conversion ticks: 2 << code gives 2, 4, 8 or 16
    always_ff @(posedge clock) begin
        if (reset || abort) begin
            running <= 1'b0;
            count   <= '0;
            target  <= '0;
            done    <= 1'b0;
        end else if (start) begin
            running <= 1'b1;
            count   <= '0;
            target  <= CNT_W'(`AQS_SAMPLE_MIN << code);
            done    <= 1'b0;
        end else begin
            done <= running && conv_tick && next_count == target;
            if (running && conv_tick) begin
                count   <= next_count;
                running <= next_count != target;
            end
        end
    end

endmodule : aqs_sample_timer

// *** rtl/aqs_sequencer.sv ***
`timescale 1ns/1ps
`include "aqs_map.svh"

// ----------------------------------------------------------------
// ----------------------------------------------------------------

module aqs_sequencer (
    input  wire logic                     clock,
    input  wire logic                     reset,
    input  wire logic [`AQS_ADDR_W-1:0]   reg_addr,
    input  wire logic                     reg_wr,
    input  wire logic                     reg_rd,
    input  wire logic [15:0]              reg_wdata,
    output logic      [15:0]              reg_rdata,
    input  wire aqs_pkg::aqs_mode_t       q1_mode,
    input  wire aqs_pkg::aqs_mode_t       q2_mode,
    input  wire logic [6:0]               second_queue_start,
    input  wire logic                     resume_at_abort,
    input  wire logic                     q1_single_go,
    input  wire logic                     q2_single_go,
    input  wire logic                     timer_expire,
    input  wire logic                     ext_trig1,
    input  wire logic                     ext_trig2,
    input  wire logic                     ext_gate,
    input  wire logic                     stop_mode,
    input  wire logic                     freeze_en,
    input  wire logic                     debug_halt,
    input  wire logic                     conv_tick,
    input  wire logic                     conv_done,
    input  wire logic [1:0]               complete_clear,
    input  wire logic [1:0]               pause_clear,
    output aqs_pkg::aqs_conv_t            conv_req,
    output logic                          conv_start,
    output logic                          sample_end,
    output logic                          conv_abort,
    output logic                          result_we,
    output logic      [5:0]               result_index,
    output logic      [5:0]               current_cmd_index,
    output logic      [3:0]               queue_status,
    output logic      [1:0]               complete_flag,
    output logic      [1:0]               pause_flag
);
    import aqs_pkg::*;

    // ----------------------------------------------------------------
    // Decoding helpers
    // ----------------------------------------------------------------
    function automatic logic is_table(input logic [`AQS_ADDR_W-1:0] addr);
        is_table = (addr >> `AQS_TABLE_SHIFT) == (`AQS_TABLE_BASE >> `AQS_TABLE_SHIFT)
                   && !addr[0];
    endfunction : is_table

    function automatic logic trig_fn(input aqs_mode_t m, input logic armed_in,
                                     input logic go, input logic rise,
                                     input logic tmr, input logic gate);
        unique case (m)
            MODE_OFF:        trig_fn = 1'b0;
            MODE_SW_SINGLE:  trig_fn = go;
            MODE_EXT_SINGLE: trig_fn = armed_in && rise;
            MODE_TMR_SINGLE: trig_fn = armed_in && tmr;
            MODE_SW_CONT:    trig_fn = 1'b1;
            MODE_EXT_CONT:   trig_fn = rise;
            MODE_TMR_CONT:   trig_fn = tmr;
            MODE_GATE_CONT:  trig_fn = gate;
        endcase
    endfunction : trig_fn

    function automatic logic [6:0] q_start(input logic q, input logic [6:0] bq2);
        q_start = q ? bq2 : `AQS_Q1_START;
    endfunction : q_start

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    aqs_state_t     state;
    aqs_cmd_t       cur_cmd;
    aqs_cmd_t       fetch_cmd;
    aqs_cmd_t       bus_cmd;
    aqs_mode_t      mode      [2];
    aqs_mode_t      prev_mode [2];
    logic           run_q;
    logic [6:0]     cur_pos;
    logic [6:0]     next_idx  [2];
    logic [6:0]     q2_sub_start;
    logic [5:0]     last_idx  [2];
    logic [1:0]     active;
    logic [1:0]     paused;
    logic [1:0]     armed;
    logic [1:0]     trig;
    logic [1:0]     mode_chg;
    logic [1:0]     ext_in;
    logic [1:0]     ext_prev;
    logic [1:0]     go;
    logic [1:0]     q_end_set;
    logic           q2_susp;
    logic           busy;
    logic           freeze_hold;
    logic           preempt;
    logic           abort_run;
    logic           fetch_end;
    logic           conv_fin;
    logic           fin_last;
    logic           fin_pause;
    logic           q_end;
    logic           sample_done;
    logic           table_we;
    logic [6:0]     pos_inc;

    assign mode[0]  = q1_mode;
    assign mode[1]  = q2_mode;
    assign ext_in   = {ext_trig2, ext_trig1};
    assign go       = {q2_single_go, q1_single_go};
    assign busy     = state != ST_IDLE;
    assign pos_inc  = cur_pos + 7'h01;
    assign freeze_hold = freeze_en && debug_halt;

    // ----------------------------------------------------------------
    // Command table and sample timing
    // ----------------------------------------------------------------
    assign table_we = reg_wr && is_table(reg_addr);

    aqs_cmd_table #(
        .DEPTH (`AQS_TABLE_DEPTH)
    ) u_table (
        .clock     (clock),
        .wr_en     (table_we),
        .wr_index  (reg_addr[6:1]),
        .wr_data   (reg_wdata[9:0]),
        .bus_index (reg_addr[6:1]),
        .bus_data  (bus_cmd),
        .seq_index (cur_pos[5:0]),
        .seq_data  (fetch_cmd)
    );

    aqs_sample_timer #(
        .CNT_W (5)
    ) u_timer (
        .clock     (clock),
        .reset     (reset),
        .start     (conv_start),
        .abort     (conv_abort),
        .code      (cur_cmd.sample_window_code),
        .conv_tick (conv_tick),
        .done      (sample_done)
    );

    // ----------------------------------------------------------------
    // Trigger sources
    // ----------------------------------------------------------------
    for (genvar q = 0; q < 2; q++) begin : g_trig
        assign mode_chg[q] = mode[q] != prev_mode[q];
        // Gate only feeds queue 1
        assign trig[q] = trig_fn(mode[q], armed[q], go[q], ext_in[q] && !ext_prev[q],
                                 timer_expire, (q == 0) && ext_gate);
        assign q_end_set[q] = q_end && (run_q == 1'(q));
    end

    always_ff @(posedge clock) begin
        for (int q = 0; q < 2; q++) begin
            if (reset || stop_mode) begin
                prev_mode[q] <= MODE_OFF;
                ext_prev[q]  <= 1'b0;
                armed[q]     <= 1'b0;
            end else begin
                prev_mode[q] <= mode[q];
                ext_prev[q]  <= ext_in[q];
                if (mode_chg[q] || (q_end_set[q] && !mode[q][2])) begin
                    armed[q] <= 1'b0;
                end else if (go[q]) begin
                    armed[q] <= 1'b1;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Sequencing events
    // ----------------------------------------------------------------
    assign preempt   = busy && run_q && active[0];
    assign abort_run = busy && (stop_mode || mode_chg[run_q] || preempt);
    // Queue 2 start at 64 or more leaves queue 1 the whole table
    assign fetch_end = state == ST_FETCH && !abort_run
                       && (cur_pos[6] || fetch_cmd.channel == `AQS_END_CHAN
                           || (!run_q && cur_pos == second_queue_start));
    assign conv_fin  = state == ST_RESOLVE && conv_done && !abort_run;
    assign fin_last  = conv_fin && cur_pos[5:0] == `AQS_LAST_ENTRY;
    assign fin_pause = conv_fin && !fin_last && cur_cmd.pause;
    assign q_end     = fetch_end || fin_last;

    // ----------------------------------------------------------------
    // Conversion state machine
    // ----------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (reset || stop_mode) begin
            state   <= ST_IDLE;
            run_q   <= 1'b0;
            cur_pos <= {1'b0, `AQS_PTR_RESET};
            cur_cmd <= '0;
        end else if (abort_run) begin
            state <= ST_IDLE;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    // Holding here under freeze keeps the next entry untouched
                    if (!freeze_hold && active != 2'b00) begin
                        run_q   <= !active[0];  // Queue 1 has priority
                        cur_pos <= active[0] ? next_idx[0] : next_idx[1];
                        state   <= ST_FETCH;
                    end
                end
                ST_FETCH: begin
                    // On a queue 2 start hit cur_pos stays there
                    if (fetch_end) begin
                        state <= ST_IDLE;
                    end else begin
                        cur_cmd <= fetch_cmd;
                        state   <= ST_SAMPLE;
                    end
                end
                ST_SAMPLE: begin
                    if (sample_done) begin
                        state <= ST_RESOLVE;
                    end
                end
                ST_RESOLVE: begin
                    if (conv_done) begin
                        state <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Queue bookkeeping
    // ----------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (reset || stop_mode) begin
            active       <= 2'b00;
            paused       <= 2'b00;
            q2_susp      <= 1'b0;
            next_idx[0]  <= `AQS_Q1_START;
            next_idx[1]  <= second_queue_start;
            q2_sub_start <= second_queue_start;
        end else begin
            if (state == ST_IDLE && !freeze_hold && !active[0] && active[1]) begin
                q2_susp <= 1'b0;
            end
            if (preempt) begin
                q2_susp     <= 1'b1;
                next_idx[1] <= resume_at_abort ? cur_pos : q2_sub_start;
            end
            if (q_end) begin
                active[run_q]   <= 1'b0;
                next_idx[run_q] <= q_start(run_q, second_queue_start);
                if (run_q) begin
                    q2_sub_start <= second_queue_start;
                end
            end else if (fin_pause) begin
                active[run_q]   <= 1'b0;
                paused[run_q]   <= 1'b1;
                next_idx[run_q] <= pos_inc;
                if (run_q) begin
                    q2_sub_start <= pos_inc;
                end
            end else if (conv_fin) begin
                next_idx[run_q] <= pos_inc;
            end
            for (int q = 0; q < 2; q++) begin
                if (mode_chg[q]) begin
                    active[q]   <= 1'b0;
                    paused[q]   <= 1'b0;
                    next_idx[q] <= q_start(q[0], second_queue_start);
                    if (q == 1) begin
                        q2_susp      <= 1'b0;
                        q2_sub_start <= second_queue_start;
                    end
                end else if (trig[q] && !active[q] && !q_end_set[q]) begin
                    active[q] <= 1'b1;
                    paused[q] <= 1'b0;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Last-entry pointers and flags
    // ----------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (reset || stop_mode) begin
            last_idx[0] <= `AQS_PTR_RESET;
            last_idx[1] <= `AQS_PTR_RESET;
        end else if (conv_fin) begin
            // Freeze never touches these; only a finished result, reset or stop changes them
            last_idx[run_q] <= cur_pos[5:0];
        end
    end

    always_ff @(posedge clock) begin
        if (reset || stop_mode) begin
            complete_flag <= 2'b00;
            pause_flag    <= 2'b00;
        end else begin
            // A set in the clearing cycle wins
            complete_flag <= (complete_flag & ~complete_clear) | q_end_set;
            pause_flag    <= (pause_flag & ~pause_clear)
                             | ({run_q, !run_q} & {2{fin_pause}});
        end
    end

    // ----------------------------------------------------------------
    // Analog core strobes
    // ----------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (reset) begin
            conv_start   <= 1'b0;
            sample_end   <= 1'b0;
            conv_abort   <= 1'b0;
            result_we    <= 1'b0;
            result_index <= '0;
            conv_req     <= '0;
        end else begin
            // Stop aborts too; disabling never powers the converter down
            conv_abort   <= abort_run;
            conv_start   <= state == ST_FETCH && !fetch_end && !abort_run;
            sample_end   <= state == ST_SAMPLE && sample_done && !abort_run;
            result_we    <= conv_fin;
            result_index <= cur_pos[5:0];
            if (state == ST_FETCH) begin
                conv_req <= '{channel:            fetch_cmd.channel,
                              amp_skip:           fetch_cmd.amp_skip,
                              sample_window_code: fetch_cmd.sample_window_code,
                              index:              cur_pos[5:0]};
            end
        end
    end

    // ----------------------------------------------------------------
    // Status and register reads
    // ----------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (reset) begin
            current_cmd_index <= `AQS_PTR_RESET;
            queue_status      <= 4'h0;
        end else begin
            current_cmd_index <= cur_pos[5:0];
            queue_status[3:2] <= active[0] ? 2'h2 : (paused[0] ? 2'h1 : 2'h0);
            queue_status[1:0] <= paused[1] ? 2'h1 :
                                 !active[1] ? 2'h0 :
                                 (q2_susp || (busy && run_q)) ? 2'h2 : 2'h3;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            if (is_table(reg_addr)) begin
                reg_rdata <= {6'h00, bus_cmd};
            end else if (reg_addr == `AQS_STATUS_ADDR) begin
                // Writes to this address are simply not decoded
                reg_rdata <= (16'(last_idx[0]) << `AQS_Q1PTR_LSB)
                             | (16'(last_idx[1]) << `AQS_Q2PTR_LSB);
            end else begin
                reg_rdata <= 16'h0000;
            end
        end
    end

endmodule : aqs_sequencer

// *** sim/aqs_seq_asserts.sv ***
`timescale 1ns/1ps
`include "aqs_map.svh"

module aqs_seq_asserts import aqs_pkg::*; (
    input wire logic        clock,
    input wire logic        reset,
    input wire logic [23:0] reg_addr,
    input wire logic        reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic        stop_mode,
    input wire logic        freeze_en,
    input wire logic        debug_halt,
    input wire logic        conv_done,
    input aqs_conv_t        conv_req,
    input wire logic        conv_start,
    input wire logic        sample_end,
    input wire logic        conv_abort,
    input wire logic        result_we,
    input wire logic [5:0]  result_index,
    input wire logic [1:0]  complete_flag
);
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    sequence s_tbl_rd;
        reg_rd && reg_addr[23:7] == 17'h00094 && !reg_addr[0];
    endsequence
    sequence s_no_early_end;
        !sample_end [*2];
    endsequence
    a_tbl_upper_zero: assert property (s_tbl_rd |=> reg_rdata[15:10] == 6'h00)
        else $error("table word upper bits not zero");
    a_stat_rsvd_zero: assert property (reg_rd && reg_addr == `AQS_STATUS_ADDR
        |=> reg_rdata[15:14] == 2'h0 && reg_rdata[7:6] == 2'h0)
        else $error("status reserved bits not zero");
    a_result_cause: assert property (result_we |-> $past(conv_done))
        else $error("result write without core completion");
    a_result_pair: assert property (result_we |-> result_index == conv_req.index)
        else $error("result index differs from entry index");
    a_sample_min: assert property (conv_start |-> ##1 s_no_early_end)
        else $error("sample window shorter than two ticks");
    a_stop_quiet: assert property (stop_mode |=> !conv_start && !result_we
        && complete_flag == 2'h0)
        else $error("activity during stop mode");
    a_abort_no_result: assert property (conv_abort |-> !result_we)
        else $error("result written with abort");
    a_freeze_hold: assert property ((freeze_en && debug_halt) [*3] |-> !conv_start)
        else $error("entry started while frozen");
endmodule : aqs_seq_asserts

bind aqs_sequencer aqs_seq_asserts chk_u (.clock, .reset, .reg_addr, .reg_rd, .reg_rdata,
    .stop_mode, .freeze_en, .debug_halt, .conv_done, .conv_req, .conv_start, .sample_end,
    .conv_abort, .result_we, .result_index, .complete_flag);

// *** sim/aqs_core_model.sv ***
`timescale 1ns/1ps

module aqs_core_model #(
    parameter int LAT = 3
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic sample_end,
    input wire logic conv_abort,
    output logic     conv_tick,
    output logic     conv_done
);
    int cnt;
    // Tick at half the module rate so sample windows span real time
    always_ff @(posedge clock) begin
        conv_tick <= reset ? 1'b0 : ~conv_tick;
        conv_done <= (cnt == 1);
        if (reset || conv_abort) begin
            cnt <= 0;
        end else if (sample_end) begin
            cnt <= LAT;
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
        end
    end
endmodule : aqs_core_model

// *** sim/tb_top.sv ***
`timescale 1ns/1ps
`include "aqs_map.svh"

module tb_top;
    import aqs_pkg::*;
    logic clock = 0, reset = 1, reg_wr = 0, reg_rd = 0, resume_at_abort = 0, ext_trig2 = 0;
    logic q1_single_go = 0, q2_single_go = 0, timer_expire = 0, ext_trig1 = 0, ext_gate = 0;
    logic stop_mode = 0, freeze_en = 0, debug_halt = 0, conv_tick, conv_done;
    logic [23:0] reg_addr = 0;
    logic [15:0] reg_wdata = 0, reg_rdata;
    logic [6:0]  second_queue_start = 7'h40;
    logic [1:0]  complete_clear = 0, pause_clear = 0, complete_flag, pause_flag;
    aqs_mode_t   q1_mode = MODE_OFF, q2_mode = MODE_OFF;
    aqs_conv_t   conv_req;
    logic        conv_start, sample_end, conv_abort, result_we;
    logic [5:0]  result_index, current_cmd_index, log_q[$];
    logic [3:0]  queue_status;
    wire logic [3:0] flags = {pause_flag, complete_flag};
    int failures = 0, checks_done = 0;
    always #25 clock = ~clock;
    aqs_sequencer dut_u (.clock, .reset, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
        .q1_mode, .q2_mode, .second_queue_start, .resume_at_abort, .q1_single_go, .q2_single_go,
        .timer_expire, .ext_trig1, .ext_trig2, .ext_gate, .stop_mode, .freeze_en, .debug_halt,
        .conv_tick, .conv_done, .complete_clear, .pause_clear, .conv_req, .conv_start,
        .sample_end, .conv_abort, .result_we, .result_index, .current_cmd_index, .queue_status,
        .complete_flag, .pause_flag);
    aqs_core_model core_u (.clock, .reset, .sample_end, .conv_abort, .conv_tick, .conv_done);
    always @(posedge clock) if (result_we) log_q.push_back(result_index);
    // ----------------------------------------------------------------
    // Access tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    function automatic logic [23:0] ent(input int n);
        return `AQS_TABLE_BASE + 24'(2 * n);
    endfunction : ent
    task automatic wr(input logic [23:0] a, input logic [15:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1;
        @(negedge clock) reg_wr = 0;
        @(negedge clock);
    endtask : wr
    task automatic rdc(input logic [23:0] a, input logic [15:0] exp);
        reg_addr = a;
        reg_rd = 1;
        @(negedge clock) reg_rd = 0;
        chk(reg_rdata, exp);
        @(negedge clock);
    endtask : rdc
    // Software go plus timer pulse; clears flags on the same edge
    task automatic trig;
        {q1_single_go, q2_single_go, timer_expire, complete_clear, pause_clear} = 7'h7f;
        @(negedge clock) {q1_single_go, q2_single_go, timer_expire, complete_clear} = 0;
        pause_clear = 0;
        @(negedge clock);
    endtask : trig
    // Bounded wait so a dead queue cannot hang the run
    task automatic wfl(input int b);
        for (int i = 0; i < 4000 && flags[b] !== 1'b1; i++) @(negedge clock);
    endtask : wfl
    task automatic test_done;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : test_done
    initial begin
        #2000000 failures++;
        test_done();
    end
    initial begin
        repeat (20) @(negedge clock);
        reset = 0;
        rdc(`AQS_STATUS_ADDR, `AQS_STATUS_RESET);
        wr(`AQS_STATUS_ADDR, 16'h0000);
        rdc(`AQS_STATUS_ADDR, `AQS_STATUS_RESET);
        rdc(24'h000100, 16'h0000);
        wr(ent(5), 16'hffff);
        rdc(ent(5), 16'h03ff);
        wr(ent(0), 16'h0001);
        wr(ent(1), 16'h01c2);
        wr(ent(2), 16'h0005);
        wr(ent(8), 16'h0204);
        wr(ent(9), 16'h003f);
        wr(ent(3), 16'h003f);
        $display("test registers done");
        second_queue_start = 7'h02;
        for (int m = 1; m < 8; m++) begin
            q1_mode = aqs_mode_t'(m);
            log_q.delete();
            // A trigger in the mode-change cycle is dropped, so let it settle
            @(negedge clock);
            trig();
            // Edge and gate only after arming, so single modes see them
            ext_trig1 = 1;
            ext_gate = 1;
            trig();
            wfl(0);
            chk(16'(complete_flag[0]), 16'h0001);
            if (m == 1) begin
                chk(16'(current_cmd_index), 16'h0002);
                chk({4'h0, log_q[0], log_q[1]}, 16'h0001);
                rdc(`AQS_STATUS_ADDR, 16'h013f);
            end
            {ext_trig1, ext_gate} = 0;
            q1_mode = MODE_OFF;
            @(negedge clock);
        end
        $display("test modes done");
        second_queue_start = 7'h08;
        q2_mode = MODE_SW_SINGLE;
        log_q.delete();
        @(negedge clock);
        trig();
        wfl(3);
        chk(16'(pause_flag[1]), 16'h0001);
        rdc(`AQS_STATUS_ADDR, 16'h0108);
        chk(16'(queue_status), 16'h0001);
        trig();
        wfl(2);
        chk({15'h0, complete_flag[1]}, 16'h0001);
        chk(16'(log_q.size()), 16'h0001);
        q2_mode = MODE_OFF;
        $display("test pause done");
        {freeze_en, debug_halt} = 2'h3;
        second_queue_start = 7'h02;
        q1_mode = MODE_SW_SINGLE;
        @(negedge clock);
        trig();
        repeat (40) @(negedge clock);
        chk(16'(complete_flag[0]), 16'h0000);
        chk(16'(queue_status), 16'h0008);
        rdc(`AQS_STATUS_ADDR, 16'h0108);
        debug_halt = 0;
        wfl(0);
        chk(16'(complete_flag[0]), 16'h0001);
        $display("test freeze done");
        // Queue 1 go lands in the long sample of queue 2 entry 1
        q2_mode = MODE_SW_SINGLE;
        second_queue_start = 7'h01;
        resume_at_abort = 1;
        log_q.delete();
        @(negedge clock) q2_single_go = 1;
        @(negedge clock) q2_single_go = 0;
        repeat (10) @(negedge clock);
        q1_single_go = 1;
        @(negedge clock) q1_single_go = 0;
        wfl(1);
        chk({4'h0, log_q[0], log_q[1]}, 16'h0001);
        chk(16'(log_q.size()), 16'h0003);
        $display("test preempt done");
        stop_mode = 1;
        repeat (3) @(negedge clock);
        chk(16'(current_cmd_index), 16'h003f);
        stop_mode = 0;
        rdc(`AQS_STATUS_ADDR, `AQS_STATUS_RESET);
        $display("test stop done");
        test_done();
    end
endmodule : tb_top
